// ==== hdl/ssf_status.sv ====
// Functional notes
// - receive completing while rx_buf_full is 1 sets rx_overrun_flag.
// - overrun flag clears on reset, standby, or read-one then write-zero.
// - dropping rx_enable leaves overrun, framing and parity flags unchanged.
// - on overrun keep old rx_buf contents, drop the new character.
// - any error flag stops reception; in synchronous mode also transmission.
// - asynchronous mode: stop bit sampled as 0 sets rx_framing_flag.
// - with two stop bits only the first is checked.
// - framing or parity error stores the character but leaves rx_buf_full clear.
// - framing flag clears on reset, standby, or read-one then write-zero.
// - asynchronous mode, parity enabled: ones count mismatching odd/even choice sets rx_parity_flag.
// - parity flag clears on reset, standby, or read-one then write-zero.
// - tx_done_flag sets on reset, standby, tx_enable low, or last bit with empty buffer.
// - tx_done_flag clears when tx_buf_empty is cleared by software or DMA write.
// - tx_done_flag is read-only, ignores writes, resets to 1.
// - asynchronous multiprocessor reception captures the received bit; read-only, resets 0.
// - dropping rx_enable keeps the captured multiprocessor bit.
// - writable tx_multiproc_bit, reset 0, is appended to multiprocessor characters.
// - tx_multiproc_bit ignored in synchronous mode, non-multiprocessor format, or idle.
// - writing 1 to buffer or error flags has no effect.
// - writing 0 clears a flag only after it was read as 1.
// - status word is 8 bits, 0x84 after reset and standby.
`timescale 1ns/1ps
`include "ssf_params.svh"

module ssf_status (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`SSF_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic standby,
    input wire ssf_pkg::ssf_rx_evt_t rx_evt,
    input wire ssf_pkg::ssf_tx_evt_t tx_evt,
    input wire ssf_pkg::ssf_dma_t dma,
    output logic rx_hold,
    output logic tx_inhibit,
    output logic tx_mp_out,
    output logic [7:0] rx_buf_data,
    output logic [7:0] tx_buf_data,
    output logic [7:0] status_word
);

    function automatic logic addr_is(input logic [`SSF_ADDR_W-1:0] a, input logic [`SSF_ADDR_W-1:0] r);
        return a == r;
    endfunction

    logic [7:0] ctrl_q;
    ssf_pkg::ssf_ctrl_t ctrl;
    logic [31:0] prdata_q;
    logic [7:0] rd_mux;
    logic [7:3] armed_q;
    logic [7:3] clr_req;
    logic txe_q, rxf_q, ore_q, fer_q, per_q, tx_done_flag_q, mpb_q, tx_multiproc_bit_q;
    logic [7:0] rx_buf_q;
    logic [7:0] tx_buf_q;
    logic setup, access, wr, rd, mapped, st_wr, st_rd;
    logic async_mode, err_any, rx_take, rx_store;
    logic ovr_evt, fer_evt, per_evt, good_rx;

    assign ctrl = ssf_pkg::ssf_ctrl_t'(ctrl_q[6:0]);
    assign async_mode = ~ctrl.sync_mode;

    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign wr = access & pwrite;
    assign rd = access & ~pwrite;
    assign mapped = addr_is(paddr, `SSF_ADDR_STATUS) | addr_is(paddr, `SSF_ADDR_CTRL) |
                    addr_is(paddr, `SSF_ADDR_RXBUF) | addr_is(paddr, `SSF_ADDR_TXBUF);
    assign st_wr = wr & addr_is(paddr, `SSF_ADDR_STATUS);
    assign st_rd = rd & addr_is(paddr, `SSF_ADDR_STATUS);

    // zero wait states: read data is captured in the setup cycle
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;
    assign prdata = prdata_q;

    assign status_word = {txe_q, rxf_q, ore_q, fer_q, per_q, tx_done_flag_q, mpb_q, tx_multiproc_bit_q};

    always_comb begin
        rd_mux = 8'h00;
        if (addr_is(paddr, `SSF_ADDR_STATUS)) begin
            rd_mux = status_word;
        end else if (addr_is(paddr, `SSF_ADDR_CTRL)) begin
            rd_mux = {1'b0, ctrl_q[6:0]};
        end else if (addr_is(paddr, `SSF_ADDR_RXBUF)) begin
            rd_mux = rx_buf_q;
        end else if (addr_is(paddr, `SSF_ADDR_TXBUF)) begin
            rd_mux = tx_buf_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup) begin
            prdata_q <= {24'h00_0000, rd_mux};
        end
    end

    // standby also drops the enables, which forces both transmit flags high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `SSF_CTRL_RST;
        end else if (standby) begin
            ctrl_q <= `SSF_CTRL_RST;
        end else if (wr && addr_is(paddr, `SSF_ADDR_CTRL)) begin
            ctrl_q <= {1'b0, pwdata[6:0]};
        end
    end

    // arming remembers a read of 1; it drops whenever the flag goes to 0
    genvar gi;
    generate
        for (gi = 3; gi <= 7; gi++) begin : g_arm
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    armed_q[gi] <= 1'b0;
                end else begin
                    armed_q[gi] <= status_word[gi] & (armed_q[gi] | (st_rd & prdata_q[gi]));
                end
            end
            assign clr_req[gi] = st_wr & ~pwdata[gi] & armed_q[gi];
        end
    endgenerate

    // errors freeze the receiver until software has cleared them
    assign err_any = ore_q | fer_q | per_q;
    assign rx_hold = err_any;
    assign tx_inhibit = ctrl.sync_mode & err_any;
    assign rx_take = rx_evt.done & ctrl.rx_enable & ~err_any;
    assign rx_store = rx_take & ~rxf_q;
    assign ovr_evt = rx_take & rxf_q;
    // stop2 is deliberately not looked at
    assign fer_evt = rx_store & async_mode & ~rx_evt.stop1;
    assign per_evt = rx_store & async_mode & ctrl.parity_en &
                     ((^rx_evt.data ^ rx_evt.parity) != ctrl.odd_parity);
    assign good_rx = rx_store & ~fer_evt & ~per_evt;

    // flag processes: a set wins over a same-cycle software or DMA clear; standby wins over a set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ore_q <= 1'b0;
        end else if (standby) begin
            ore_q <= 1'b0;
        end else if (ovr_evt) begin
            ore_q <= 1'b1;
        end else if (clr_req[`SSF_BIT_ORE]) begin
            ore_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fer_q <= 1'b0;
        end else if (standby) begin
            fer_q <= 1'b0;
        end else if (fer_evt) begin
            fer_q <= 1'b1;
        end else if (clr_req[`SSF_BIT_FER]) begin
            fer_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            per_q <= 1'b0;
        end else if (standby) begin
            per_q <= 1'b0;
        end else if (per_evt) begin
            per_q <= 1'b1;
        end else if (clr_req[`SSF_BIT_PER]) begin
            per_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxf_q <= 1'b0;
        end else if (standby) begin
            rxf_q <= 1'b0;
        end else if (good_rx) begin
            rxf_q <= 1'b1;
        end else if (clr_req[`SSF_BIT_RXF] || dma.rx_read) begin
            rxf_q <= 1'b0;
        end
    end

    // erroneous characters still land in the buffer; overrun ones do not
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_buf_q <= 8'h00;
        end else if (rx_store) begin
            rx_buf_q <= rx_evt.data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mpb_q <= 1'b0;
        end else if (standby) begin
            mpb_q <= 1'b0;
        end else if (rx_store && async_mode && ctrl.mp_format) begin
            mpb_q <= rx_evt.mp;
        end
    end

    // load wins over a same-cycle clear so the flag never hides a free buffer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txe_q <= 1'b1;
        end else if (standby || !ctrl.tx_enable || tx_evt.load) begin
            txe_q <= 1'b1;
        end else if (clr_req[`SSF_BIT_TXE] || dma.tx_write) begin
            txe_q <= 1'b0;
        end
    end

    // no write path of its own: writing its bit never changes it, only a TXE clear or DMA write drops it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_done_flag_q <= 1'b1;
        end else if (standby || !ctrl.tx_enable || (tx_evt.last_bit && txe_q)) begin
            tx_done_flag_q <= 1'b1;
        end else if (clr_req[`SSF_BIT_TXE] || dma.tx_write) begin
            tx_done_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_buf_q <= 8'h00;
        end else if (dma.tx_write) begin
            tx_buf_q <= dma.tx_data;
        end else if (wr && addr_is(paddr, `SSF_ADDR_TXBUF)) begin
            tx_buf_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_multiproc_bit_q <= 1'b0;
        end else if (standby) begin
            tx_multiproc_bit_q <= 1'b0;
        end else if (st_wr) begin
            tx_multiproc_bit_q <= pwdata[`SSF_BIT_TX_MULTIPROC_BIT];
        end
    end

    // gating keeps a stale bit off the line between characters
    assign tx_mp_out = tx_multiproc_bit_q & async_mode & ctrl.mp_format & tx_evt.busy;
    assign rx_buf_data = rx_buf_q;
    assign tx_buf_data = tx_buf_q;

    a_overrun_set: assert property (@(posedge pclk) disable iff (!presetn)
        ovr_evt && !standby |=> ore_q && rxf_q)
        else $error("overrun not flagged");

    a_overrun_keeps_buf: assert property (@(posedge pclk) disable iff (!presetn)
        ovr_evt |=> rx_buf_q == $past(rx_buf_q))
        else $error("overrun replaced buffer");

    a_clear_needs_read: assert property (@(posedge pclk) disable iff (!presetn)
        st_wr && !pwdata[`SSF_BIT_ORE] && !armed_q[`SSF_BIT_ORE] && !standby && !ovr_evt |=> ore_q == $past(ore_q))
        else $error("flag cleared without prior read");

    a_write_one_inert: assert property (@(posedge pclk) disable iff (!presetn)
        st_wr && pwdata[`SSF_BIT_ORE] && !ore_q && !ovr_evt |=> !ore_q)
        else $error("write of one set a flag");

    a_read_clear_seq: assert property (@(posedge pclk) disable iff (!presetn)
        st_rd && prdata_q[`SSF_BIT_ORE] ##[2:3] (st_wr && !pwdata[`SSF_BIT_ORE] && !ovr_evt) |=> !ore_q)
        else $error("read then write zero did not clear");

    a_standby_init: assert property (@(posedge pclk) disable iff (!presetn)
        standby |=> status_word == `SSF_STATUS_RST)
        else $error("status word not 0x84 after standby");

    a_second_stop_free: assert property (@(posedge pclk) disable iff (!presetn)
        rx_store && async_mode && rx_evt.stop1 && !rx_evt.stop2 && !standby |=> !fer_q)
        else $error("second stop bit was checked");

    a_error_no_full: assert property (@(posedge pclk) disable iff (!presetn)
        (fer_evt || per_evt) && !standby |=> !rxf_q && rx_buf_q == $past(rx_evt.data) && (fer_q || per_q))
        else $error("error character handled wrongly");

    a_error_holds_rx: assert property (@(posedge pclk) disable iff (!presetn)
        err_any && rx_evt.done |-> rx_hold && tx_inhibit == ctrl.sync_mode ##1 rx_buf_q == $past(rx_buf_q))
        else $error("reception continued during error");

    a_sync_no_check: assert property (@(posedge pclk) disable iff (!presetn)
        rx_take && ctrl.sync_mode |=> !fer_q && !per_q)
        else $error("check made in synchronous mode");

    a_tx_done_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        tx_evt.last_bit && txe_q |=> tx_done_flag_q)
        else $error("transmit done not set");

    a_tx_done_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
        dma.tx_write && ctrl.tx_enable && !tx_evt.last_bit && !tx_evt.load && !standby |=> !tx_done_flag_q && !txe_q)
        else $error("transmit done not cleared by DMA write");

    a_tx_multiproc_bit_gate: assert property (@(posedge pclk) disable iff (!presetn)
        tx_mp_out |-> async_mode && ctrl.mp_format && tx_evt.busy && tx_multiproc_bit_q)
        else $error("multiprocessor bit sent when ignored");

    a_rx_off_keeps: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl.rx_enable && !standby && !clr_req[`SSF_BIT_ORE] && !clr_req[`SSF_BIT_FER] && !clr_req[`SSF_BIT_PER]
        |=> ore_q == $past(ore_q) && fer_q == $past(fer_q) && per_q == $past(per_q))
        else $error("error flags changed with receiver off");

    a_mpb_kept: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl.rx_enable && !standby |=> mpb_q == $past(mpb_q))
        else $error("multiprocessor bit changed with receiver off");

    a_mpb_capture: assert property (@(posedge pclk) disable iff (!presetn)
        rx_store && async_mode && ctrl.mp_format && !standby |=> mpb_q == $past(rx_evt.mp))
        else $error("received multiprocessor bit not captured");

    a_tx_off_done: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl.tx_enable |=> tx_done_flag_q && txe_q)
        else $error("transmit flags low with transmitter off");

    a_tx_done_flag_readonly: assert property (@(posedge pclk) disable iff (!presetn)
        st_wr && tx_done_flag_q && !clr_req[`SSF_BIT_TXE] && !dma.tx_write && !standby |=> tx_done_flag_q)
        else $error("write changed transmit done");

    a_write_one_txe: assert property (@(posedge pclk) disable iff (!presetn)
        st_wr && pwdata[`SSF_BIT_TXE] && !txe_q && ctrl.tx_enable && !tx_evt.load && !standby |=> !txe_q)
        else $error("write of one set buffer empty");

    c_overrun: cover property (@(posedge pclk) disable iff (!presetn) ovr_evt);
    c_framing: cover property (@(posedge pclk) disable iff (!presetn) fer_evt);
    c_sw_clear: cover property (@(posedge pclk) disable iff (!presetn) clr_req[`SSF_BIT_ORE] ##1 !ore_q);
    c_tx_end: cover property (@(posedge pclk) disable iff (!presetn) !tx_done_flag_q ##1 tx_done_flag_q);
    c_parity: cover property (@(posedge pclk) disable iff (!presetn) per_evt);

endmodule

// ==== inc/ssf_params.svh ====
`ifndef SSF_PARAMS_SVH
`define SSF_PARAMS_SVH

`define SSF_ADDR_W 12
`define SSF_ADDR_STATUS 12'h000
`define SSF_ADDR_CTRL 12'h004
`define SSF_ADDR_RXBUF 12'h008
`define SSF_ADDR_TXBUF 12'h00c

`define SSF_BIT_TXE 7
`define SSF_BIT_RXF 6
`define SSF_BIT_ORE 5
`define SSF_BIT_FER 4
`define SSF_BIT_PER 3
`define SSF_BIT_TX_DONE_FLAG 2
`define SSF_BIT_MPB 1
`define SSF_BIT_TX_MULTIPROC_BIT 0

`define SSF_STATUS_RST 8'h84
`define SSF_CTRL_RST 8'h00

`endif

// ==== inc/ssf_pkg.sv ====
package ssf_pkg;

    // control word, bit 7 unused and reads zero
    typedef struct packed {
        logic tx_enable;
        logic rx_enable;
        logic two_stop;
        logic odd_parity;
        logic parity_en;
        logic mp_format;
        logic sync_mode;
    } ssf_ctrl_t;

    typedef struct packed {
        logic done;
        logic [7:0] data;
        logic parity;
        logic stop1;
        logic stop2;
        logic mp;
    } ssf_rx_evt_t;

    typedef struct packed {
        logic load;
        logic last_bit;
        logic busy;
    } ssf_tx_evt_t;

    typedef struct packed {
        logic tx_write;
        logic [7:0] tx_data;
        logic rx_read;
    } ssf_dma_t;

endpackage

// ==== sim/ssf_line_model.sv ====
`timescale 1ns/1ps

module ssf_line_model (
    input wire logic pclk,
    input wire logic rx_go,
    input wire logic [7:0] rx_byte,
    input wire logic [1:0] rx_stops,
    input wire logic rx_par_ok,
    input wire logic rx_odd,
    input wire logic rx_mp,
    input wire logic tx_go,
    output ssf_pkg::ssf_rx_evt_t rx_evt,
    output ssf_pkg::ssf_tx_evt_t tx_evt
);
    logic [2:0] tx_cnt_q;
    logic par;

    initial begin
        rx_evt = '0;
        tx_evt = '0;
        tx_cnt_q = 3'h0;
    end

    assign par = (^rx_byte) ^ rx_odd ^ ~rx_par_ok;

    // fields flip between characters so stale data never looks valid
    always @(posedge pclk) begin
        rx_evt <= rx_go ? {1'b1, rx_byte, par, rx_stops, rx_mp} : {1'b0, ~rx_evt[11:0]};
    end

    always @(posedge pclk) begin
        tx_cnt_q <= tx_go ? 3'h5 : ((tx_cnt_q != 3'h0) ? tx_cnt_q - 3'h1 : 3'h0);
        tx_evt.load <= tx_go;
        tx_evt.busy <= tx_go || (tx_cnt_q > 3'h1);
        tx_evt.last_bit <= (tx_cnt_q == 3'h1);
    end
endmodule

// ==== sim/serial_status_flags_tb.sv ====
`timescale 1ns/1ps
`include "ssf_params.svh"

module serial_status_flags_tb;
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] data;
        logic [1:0] stops;
        logic pok;
        logic mp;
        logic [7:0] st;
    } ssf_row_t;
    localparam ssf_row_t ROWS [8] = '{
        '{8'h20, 8'h5a, 2'h3, 1'b1, 1'b0, 8'hc4},
        '{8'h20, 8'ha5, 2'h1, 1'b1, 1'b0, 8'h94},
        '{8'h30, 8'h3c, 2'h2, 1'b1, 1'b0, 8'hc4},
        '{8'h24, 8'h81, 2'h3, 1'b0, 1'b0, 8'h8c},
        '{8'h2c, 8'h7e, 2'h3, 1'b1, 1'b0, 8'hc4},
        '{8'h2c, 8'h7e, 2'h3, 1'b0, 1'b0, 8'h8c},
        '{8'h25, 8'hc3, 2'h0, 1'b0, 1'b0, 8'hc4},
        '{8'h22, 8'h11, 2'h3, 1'b1, 1'b1, 8'hc6}
    };
    logic pclk, presetn, psel, penable, pwrite, standby, pready, pslverr, rerr;
    logic rx_hold, tx_inhibit, tx_mp_out, rx_go, rx_par_ok, rx_odd, rx_mp, tx_go;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [7:0] rx_buf_data, tx_buf_data, status_word, rx_byte, ctrl_v;
    logic [1:0] rx_stops;
    ssf_pkg::ssf_rx_evt_t rx_evt;
    ssf_pkg::ssf_tx_evt_t tx_evt;
    ssf_pkg::ssf_dma_t dma;
    int n_fail = 0;
    int n_compared = 0;

    ssf_status uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .standby(standby), .rx_evt(rx_evt), .tx_evt(tx_evt), .dma(dma), .rx_hold(rx_hold),
        .tx_inhibit(tx_inhibit), .tx_mp_out(tx_mp_out), .rx_buf_data(rx_buf_data),
        .tx_buf_data(tx_buf_data), .status_word(status_word));
    ssf_line_model line (.pclk(pclk), .rx_go(rx_go), .rx_byte(rx_byte), .rx_stops(rx_stops),
        .rx_par_ok(rx_par_ok), .rx_odd(rx_odd), .rx_mp(rx_mp), .tx_go(tx_go), .rx_evt(rx_evt),
        .tx_evt(tx_evt));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        if (n == 20) chk("pready", pready, 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wctl(input logic [7:0] d);
        ctrl_v = d;
        apb(1'b1, `SSF_ADDR_CTRL, d);
    endtask

    task automatic send(input logic [7:0] b, input logic [1:0] s, input logic pok, input logic mp);
        rx_go <= 1'b1;
        rx_byte <= b;
        rx_stops <= s;
        rx_par_ok <= pok;
        rx_mp <= mp;
        rx_odd <= ctrl_v[3];
        @(posedge pclk);
        rx_go <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask

    task automatic sby;
        standby <= 1'b1;
        @(posedge pclk);
        standby <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("status after standby", status_word, 8'h84);
    endtask

    task automatic txrun(input logic mpx, input logic [7:0] st);
        tx_go <= 1'b1;
        @(posedge pclk);
        tx_go <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("tx_mp_out busy", tx_mp_out, mpx);
        repeat (6) @(posedge pclk);
        chk("tx_mp_out idle", tx_mp_out, 1'b0);
        chk("status after tx", status_word, st);
    endtask

    task automatic dmaw(input logic [7:0] d);
        dma <= '{1'b1, d, 1'b0};
        @(posedge pclk);
        dma <= '0;
        repeat (2) @(posedge pclk);
        chk("tx_buf_data", tx_buf_data, d);
        chk("status after dma", status_word, 8'h01);
    endtask

    // generous: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge pclk);
        n_fail++;
        stop_test;
    end

    initial begin
        {psel, penable, pwrite, standby, rx_go, tx_go, rx_par_ok, rx_odd, rx_mp} = '0;
        paddr = '0;
        pwdata = '0;
        rx_byte = '0;
        rx_stops = '0;
        dma = '0;
        ctrl_v = '0;
        presetn = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("status reset", status_word, 8'h84);
        apb(1'b0, `SSF_ADDR_STATUS, 8'h00);
        chk("status read", rdat, 32'h84);
        foreach (ROWS[i]) begin
            wctl(ROWS[i].ctrl);
            send(ROWS[i].data, ROWS[i].stops, ROWS[i].pok, ROWS[i].mp);
            chk("status row", status_word, ROWS[i].st);
            chk("rx_buf row", rx_buf_data, ROWS[i].data);
            chk("rx_hold row", rx_hold, |ROWS[i].st[5:3]);
            sby;
        end
        wctl(8'h22);
        send(8'h44, 2'h3, 1'b1, 1'b1);
        wctl(8'h02);
        chk("mp bit kept", status_word[1], 1'b1);
        sby;
        // sync mode: overrun, then a refused third character
        wctl(8'h21);
        send(8'h5a, 2'h3, 1'b1, 1'b0);
        send(8'h33, 2'h3, 1'b1, 1'b0);
        send(8'h99, 2'h3, 1'b1, 1'b0);
        chk("overrun", status_word, 8'he4);
        chk("rx_buf kept", rx_buf_data, 8'h5a);
        chk("hold and inhibit", {rx_hold, tx_inhibit}, 2'h3);
        wctl(8'h01);
        apb(1'b1, `SSF_ADDR_STATUS, 8'h00);
        chk("unread clear", status_word, 8'he4);
        apb(1'b0, `SSF_ADDR_STATUS, 8'h00);
        apb(1'b1, `SSF_ADDR_STATUS, 8'hfe);
        chk("write ones", status_word, 8'he4);
        apb(1'b0, `SSF_ADDR_STATUS, 8'h00);
        apb(1'b1, `SSF_ADDR_STATUS, 8'hdf);
        chk("overrun clear", status_word, 8'hc5);
        sby;
        wctl(8'h42);
        apb(1'b0, `SSF_ADDR_STATUS, 8'h00);
        apb(1'b1, `SSF_ADDR_STATUS, 8'h01);
        chk("tx start", status_word, 8'h01);
        txrun(1'b1, 8'h85);
        dmaw(8'h6b);
        apb(1'b1, `SSF_ADDR_STATUS, 8'hc7);
        chk("read-only bits", status_word, 8'h01);
        wctl(8'h40);
        txrun(1'b0, 8'h85);
        dmaw(8'h2d);
        wctl(8'h00);
        @(posedge pclk);
        chk("tx off", status_word, 8'h85);
        presetn <= 1'b0;
        @(posedge pclk);
        chk("status mid reset", status_word, 8'h84);
        presetn <= 1'b1;
        apb(1'b0, 12'h010, 8'h00);
        chk("unmapped err", rerr, 1'b1);
        chk("unmapped data", rdat, 32'h0);
        stop_test;
    end
endmodule
